// *** rtl/dram_ctrl_regs.vh ***
// constants for the cached dram controller: timing counts, decode values,
// state codes and field positions
// assumes ref_clk at 100 MHz
`ifndef DRAM_CTRL_REGS_VH
`define DRAM_CTRL_REGS_VH

`define CLK_PERIOD_NS      10
`define REFRESH_PERIOD_NS  62000
`define REFRESH_CYCLES     (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)
`define REFRESH_CNT_W      13
`define INIT_REFRESH_COUNT 4'h8

// address decode: top byte zero, lowest 16 Mbyte
`define DECODE_HI          8'h00
// transfer mode codes for user and supervisor data and code
`define TM_USER_DATA       3'h1
`define TM_USER_CODE       3'h2
`define TM_SUPV_DATA       3'h5
`define TM_SUPV_CODE       3'h6
// transfer type: normal access
`define TT_NORMAL          2'h0
// transfer size encodings
`define SIZE_LONG          2'h0
`define SIZE_BYTE          2'h1
`define SIZE_WORD          2'h2
`define SIZE_LINE          2'h3

// address fields: column a[12:2], row a[23:13]
`define COL_LSB            2
`define ROW_LSB            13
`define BANK_LSB           22
`define LAST_ROW_W         13

// state codes
`define ST_I1              5'h00
`define ST_I2              5'h01
`define ST_R1              5'h02
`define ST_R2              5'h03
`define ST_R3              5'h04
`define ST_R4              5'h05
`define ST_RB              5'h06
`define ST_W1              5'h07
`define ST_W2              5'h08
`define ST_W3              5'h09
`define ST_W4              5'h0A
`define ST_WB              5'h0B
`define ST_F1              5'h0C
`define ST_F2              5'h0D
`define ST_F3              5'h0E
`define ST_F4              5'h0F
`define ST_RST             5'h10

`endif

// *** rtl/refresh_timer.v ***
// refresh interval divider: one-cycle pulse every period cycles
// assumes a single synchronous clock and an already synchronised reset
`timescale 1ns/1ns
module refresh_timer
#(
    parameter WIDTH  = 13,
    parameter PERIOD = 6200
)
(
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // tick out
    output reg              tick
);
    reg [WIDTH-1:0] count_reg;

    // free-running down counter, reload on zero
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= {WIDTH{1'b0}};
            tick      <= 1'b0;
        end
        else if (count_reg == {WIDTH{1'b0}})
        begin
            count_reg <= PERIOD[WIDTH-1:0] - 1'b1;
            tick      <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg - 1'b1;
            tick      <= 1'b0;
        end
    end
endmodule // refresh_timer

// *** rtl/cached_dram_controller.v ***
// synchronous controller between a 32-bit processor bus and four banks of
// cached dram modules; all pins sampled and driven on ref_clk
// Summary of operation
// - divide clock into 62 us refresh trigger
// - service refresh at next free cycle
// - 13-bit last row holds row and bank
// - compare row and bank on reads
// - address mux: row, column or burst
// - burst low bits wrap modulo four
// - decode a[31:24] and mode, low 16M
// - reset low: init, eight refresh cycles
// - after reset release go idle
// - start on strobe plus address or refresh
// - read hit: column, oe, select, ack
// - burst read ..new address per pair
// - read miss row, read, select, row enable
// - miss column, oe, ack
// - write strobes only the addressed bytes
// - W1: row, write mode, select, ack; row enable from W2
// - W2 column strobes; W3 release; W4 row off unless burst
// - burst write loops in WB page mode, ack each
// - refresh F1 with refresh mode, end F3
// - F3/F4 accept next event; hit to
`timescale 1ns/1ns
`include "dram_ctrl_regs.vh"
module cached_dram_controller
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        processor_reset_in_n,
    // processor bus
    input  wire [31:0] addr,
    input  wire [1:0]  transfer_type,
    input  wire [2:0]  transfer_mode_bits,
    input  wire [1:0]  transfer_size,
    input  wire        read_write,
    input  wire        transfer_start_n,
    input  wire        cache_inhibit_n,
    output reg         transfer_ack_n,
    // memory address
    output reg  [9:0]  mux_addr_low_banks,
    output reg  [9:0]  mux_addr_high_banks,
    output reg         bank0_addr_bit10,
    output reg         bank1_addr_bit10,
    output reg         bank2_addr_bit10,
    output reg         bank3_addr_bit10,
    // memory control
    output reg  [3:0]  row_enable_n,
    output reg  [3:0]  col_latch_n,
    output reg  [1:0]  write_mode,
    output reg  [1:0]  refresh_mode_n,
    output reg  [3:0]  chip_select_n,
    output reg  [1:0]  output_enable_n,
    output reg  [1:0]  write_enable_n
);
    // reset release through two flops
    reg        rst_meta_reg;
    reg        rst_sync_reg;
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // refresh trigger
    wire       refresh_tick;
    refresh_timer
    #(
        .WIDTH  (`REFRESH_CNT_W),
        .PERIOD (`REFRESH_CYCLES)
    )
    i_refresh_timer
    (
        .clk   (ref_clk),
        .rst_n (rst_sync_reg),
        .tick  (refresh_tick)
    );

    // state and captured transfer
    reg [4:0]  state_reg,  state_next;
    reg [`LAST_ROW_W-1:0] last_row_register;
    reg        last_row_valid_reg;
    reg [31:0] addr_reg;
    reg        burst_reg;
    reg [3:0]  byte_sel_reg;
    reg [1:0]  beat_reg;
    reg [1:0]  beat_cnt_reg;
    reg        refresh_pending_reg;
    reg [3:0]  init_cnt_reg;
    reg        evt_reg;
    reg        evt_wr_reg;

    // address decode and hit compare on live bus
    wire mode_ok = (transfer_mode_bits == `TM_USER_DATA) ||
                   (transfer_mode_bits == `TM_USER_CODE) ||
                   (transfer_mode_bits == `TM_SUPV_DATA) ||
                   (transfer_mode_bits == `TM_SUPV_CODE);
    wire addr_ok = (addr[31:24] == `DECODE_HI) && mode_ok &&
                   (transfer_type == `TT_NORMAL);
    wire start   = !transfer_start_n && addr_ok;
    wire [`LAST_ROW_W-1:0] new_row = addr[`ROW_LSB+`LAST_ROW_W-1:`ROW_LSB];
    wire hit     = last_row_valid_reg && (new_row == last_row_register);
    wire is_line = (transfer_size == `SIZE_LINE);
    wire cap     = start && (state_reg == `ST_I2 || state_reg == `ST_F3 ||
                             state_reg == `ST_F4);
    // pins follow the next state, so they must see the address taken now
    wire [31:0] addr_n = cap ? addr : addr_reg;
    wire [1:0] bank = addr_n[`BANK_LSB+1:`BANK_LSB];
    wire [3:0] bank_dec = 4'h1 << bank;
    // low banks 0/1 share one group of control lines, high 2/3 the other
    wire [1:0] grp_dec = bank[1] ? 2'h2 : 2'h1;

    // byte lanes from size and low address bits, big-endian lanes
    function [3:0] lanes;
        input [1:0] sz;
        input [1:0] a;
        begin
            case (sz)
                `SIZE_BYTE: lanes = 4'h8 >> a;
                `SIZE_WORD: lanes = a[1] ? 4'h3 : 4'hC;
                default:    lanes = 4'hF;
            endcase
        end
    endfunction

    // refresh request held until serviced; new tick wins over clear
    always @(posedge ref_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            refresh_pending_reg <= 1'b0;
        else if (refresh_tick)
            refresh_pending_reg <= 1'b1;
        else if (state_reg == `ST_F1)
            refresh_pending_reg <= 1'b0;
    end

    // next state; bus events only start from idle or refresh tail
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `ST_RST:
                if (processor_reset_in_n && init_cnt_reg == `INIT_REFRESH_COUNT)
                    state_next = `ST_I2;
                else if (init_cnt_reg != `INIT_REFRESH_COUNT)
                    state_next = `ST_F1;
            `ST_I1:
                if (evt_reg)
                    state_next = evt_wr_reg ? `ST_W1 : `ST_R1;
                else
                    state_next = `ST_I2; // precharge wait
            `ST_I2:
                if (refresh_pending_reg)
                    state_next = `ST_F1;
                else if (start && !read_write)
                    state_next = `ST_W1;
                else if (start && hit)
                    state_next = `ST_R3;
                else if (start)
                    state_next = `ST_R1;
            `ST_R1: state_next = `ST_R2;
            `ST_R2: state_next = `ST_R3;
            `ST_R3: state_next = burst_reg ? `ST_R4 : `ST_I2;
            `ST_R4: state_next = `ST_RB;
            `ST_RB:
                state_next = (beat_cnt_reg == 2'h3) ? `ST_I2 : `ST_RB;
            `ST_W1: state_next = `ST_W2;
            `ST_W2: state_next = `ST_W3;
            `ST_W3: state_next = `ST_W4;
            `ST_W4: state_next = burst_reg ? `ST_WB : `ST_I1;
            `ST_WB:
                state_next = (beat_cnt_reg == 2'h3) ? `ST_I1 : `ST_WB;
            `ST_F1: state_next = `ST_F2;
            `ST_F2: state_next = `ST_F3;
            `ST_F3, `ST_F4:
                if (!processor_reset_in_n || init_cnt_reg != `INIT_REFRESH_COUNT)
                    state_next = (state_reg == `ST_F3) ? `ST_F4 : `ST_RST;
                else if (start && read_write && hit)
                    state_next = `ST_R3;
                else if (start)
                    state_next = `ST_I1;
                else if (state_reg == `ST_F4)
                    state_next = `ST_I2;
                else
                    state_next = `ST_F4;
            default: state_next = `ST_I2;
        endcase
    end

    // state register, transfer capture, last row, beat counters
    always @(posedge ref_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg          <= `ST_RST;
            init_cnt_reg       <= 4'h0;
            last_row_register  <= {`LAST_ROW_W{1'b0}};
            last_row_valid_reg <= 1'b0;
            addr_reg           <= 32'h00000000;
            burst_reg          <= 1'b0;
            byte_sel_reg       <= 4'h0;
            beat_reg           <= 2'h0;
            beat_cnt_reg       <= 2'h0;
            evt_reg            <= 1'b0;
            evt_wr_reg         <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // processor reset reopens the init refresh burst
            if (!processor_reset_in_n && state_reg == `ST_I2)
                state_reg <= `ST_RST;
            if (!processor_reset_in_n && state_reg == `ST_RST &&
                init_cnt_reg == `INIT_REFRESH_COUNT)
                init_cnt_reg <= 4'h0;
            else if (state_reg == `ST_F1 && init_cnt_reg != `INIT_REFRESH_COUNT)
                init_cnt_reg <= init_cnt_reg + 4'h1;
            if (start && (state_reg == `ST_I2 || state_reg == `ST_F3 ||
                          state_reg == `ST_F4))
            begin
                addr_reg     <= addr;
                burst_reg    <= is_line && cache_inhibit_n;
                byte_sel_reg <= lanes(transfer_size, addr[1:0]);
                beat_reg     <= addr[3:2];
                beat_cnt_reg <= 2'h0;
                evt_wr_reg   <= !read_write;
            end
            // strobe is gone by I1, so the taken request is kept here
            evt_reg <= cap && (state_next == `ST_I1);
            if (state_reg == `ST_R1)
            begin
                last_row_register  <= addr_reg[`ROW_LSB+`LAST_ROW_W-1:`ROW_LSB];
                last_row_valid_reg <= 1'b1;
            end
            // one beat per two-cycle pair, wrapping modulo four
            if ((state_reg == `ST_RB || state_reg == `ST_WB) && addr_reg[0])
                beat_cnt_reg <= beat_cnt_reg + 2'h1;
            if ((state_reg == `ST_RB || state_reg == `ST_WB) && addr_reg[0])
                beat_reg <= beat_reg + 2'h1;
            if (state_reg == `ST_RB || state_reg == `ST_WB)
                addr_reg[0] <= ~addr_reg[0];
            else if (state_reg == `ST_R4 || state_reg == `ST_W4)
                addr_reg[0] <= 1'b0;
        end
    end

    // pin outputs registered from the next state
    // beat of the coming cycle, so each ack but the W1 write ack carries its own column
    wire [1:0]  beat_n = cap ? addr[3:2] :
                         (((state_reg == `ST_RB) || (state_reg == `ST_WB)) && addr_reg[0]) ?
                         beat_reg + 2'h1 : beat_reg;
    wire [10:0] row_a = addr_n[`ROW_LSB+10:`ROW_LSB];
    wire [10:0] col_a = {addr_n[12:4], beat_n};
    wire n_row   = (state_next == `ST_R1) || (state_next == `ST_R2) ||
                   (state_next == `ST_W1);
    wire n_rd    = (state_next == `ST_R3) || (state_next == `ST_R4) ||
                   (state_next == `ST_RB);
    wire n_wcol  = (state_next == `ST_W2) || (state_next == `ST_WB);
    wire n_wstb  = (state_next == `ST_W2) ||
                   ((state_next == `ST_WB) && state_reg == `ST_WB && addr_reg[0]);
    wire n_ref   = (state_next == `ST_F1) || (state_next == `ST_F2);
    wire n_re    = n_ref || (state_next == `ST_R1) || (state_next == `ST_R2) ||
                   (state_next == `ST_W2) || (state_next == `ST_W3) ||
                   (state_next == `ST_WB) || (state_next == `ST_W4 && burst_reg);
    wire n_wr    = (state_next >= `ST_W1) && (state_next <= `ST_WB);
    wire n_ack   = (state_next == `ST_R3) || (state_next == `ST_W1) ||
                   (((state_next == `ST_RB) || (state_next == `ST_WB)) &&
                    state_reg != `ST_R4 && state_reg != `ST_W4 && addr_reg[0]);
    wire [10:0] ma = n_row ? row_a : col_a;

    always @(posedge ref_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            transfer_ack_n      <= 1'b1;
            mux_addr_low_banks  <= 10'h000;
            mux_addr_high_banks <= 10'h000;
            bank0_addr_bit10    <= 1'b0;
            bank1_addr_bit10    <= 1'b0;
            bank2_addr_bit10    <= 1'b0;
            bank3_addr_bit10    <= 1'b0;
            row_enable_n        <= 4'hF;
            col_latch_n         <= 4'hF;
            write_mode          <= 2'h0;
            refresh_mode_n      <= 2'h3;
            chip_select_n       <= 4'hF;
            output_enable_n     <= 2'h3;
            write_enable_n      <= 2'h3;
        end
        else
        begin
            mux_addr_low_banks  <= ma[9:0];
            mux_addr_high_banks <= ma[9:0];
            bank0_addr_bit10    <= ma[10];
            bank1_addr_bit10    <= ma[10];
            bank2_addr_bit10    <= ma[10];
            bank3_addr_bit10    <= ma[10];
            transfer_ack_n      <= ~n_ack;
            // refresh drives every bank at once
            row_enable_n        <= n_ref ? 4'h0 : (n_re ? ~bank_dec : 4'hF);
            refresh_mode_n      <= n_ref ? 2'h0 : 2'h3;
            chip_select_n       <= (n_row || n_rd || n_wr) ? ~bank_dec : 4'hF;
            write_mode          <= n_wr ? grp_dec : 2'h0;
            output_enable_n     <= n_rd ? ~grp_dec : 2'h3;
            col_latch_n         <= n_wstb ? ~byte_sel_reg : 4'hF;
            write_enable_n      <= n_wstb ? ~grp_dec : 2'h3;
            if (n_wcol && !n_wstb)
                col_latch_n     <= 4'hF;
        end
    end
endmodule // cached_dram_controller

// *** tb/dram_ctrl_monitor.sv ***
// pin-level assertions for the cached dram controller
// bound into every cached_dram_controller, sees its ports only
`timescale 1ns/1ns
module dram_ctrl_monitor
(
    // clock and reset
    input wire        ref_clk,
    input wire        arst_n,
    input wire        processor_reset_in_n,
    // processor bus
    input wire [31:0] addr,
    input wire        read_write,
    input wire        transfer_start_n,
    input wire        transfer_ack_n,
    // memory control
    input wire [3:0]  row_enable_n,
    input wire [3:0]  col_latch_n,
    input wire [1:0]  write_mode,
    input wire [1:0]  refresh_mode_n,
    input wire [3:0]  chip_select_n,
    input wire [1:0]  output_enable_n,
    input wire [1:0]  write_enable_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // acks only ever accompany an active memory cycle
    property p_ack_cs; !transfer_ack_n |-> chip_select_n != 4'hF; endproperty
    a_ack_cs: assert property (p_ack_cs) else $error("ack without select");
    property p_rd_oe; !transfer_ack_n && read_write |-> output_enable_n != 2'h3; endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read ack without oe");
    property p_wr_mode; !transfer_ack_n && !read_write |-> write_mode != 2'h0; endproperty
    a_wr_mode: assert property (p_wr_mode) else $error("write ack in read mode");
    // refresh needs the row strobe within a cycle of refresh mode
    property p_rf_re; $fell(refresh_mode_n == 2'h3) |-> ##[0:1] row_enable_n != 4'hF; endproperty
    a_rf_re: assert property (p_rf_re) else $error("refresh without row enable");
    property p_rf_nowr; refresh_mode_n != 2'h3 |-> write_enable_n == 2'h3; endproperty
    a_rf_nowr: assert property (p_rf_nowr) else $error("write during refresh");
    property p_we_cal; write_enable_n != 2'h3 |-> col_latch_n != 4'hF; endproperty
    a_we_cal: assert property (p_we_cal) else $error("write enable without latch");
    // single-cycle ack; burst beats from the second on come every second cycle
    property p_ack_one; !transfer_ack_n |=> transfer_ack_n; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
    property p_bad_addr; !transfer_start_n && addr[31:24] != 8'h00 |=> transfer_ack_n [*8]; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("ack outside decode");
    property p_rst_quiet; !processor_reset_in_n |-> transfer_ack_n; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("ack during reset");

    // main scenarios reached
    c_ack: cover property (!transfer_ack_n);
    c_rf: cover property ($fell(refresh_mode_n == 2'h3));
    c_we: cover property (write_enable_n != 2'h3);
endmodule // dram_ctrl_monitor

bind cached_dram_controller dram_ctrl_monitor i_dram_ctrl_monitor (.*);

// *** tb/bus_master.sv ***
// processor bus master model, one transfer at a time
// drives and samples on the falling edge of ref_clk
`timescale 1ns/1ns
module bus_master
(
    // clock and answer
    input  wire        ref_clk,
    input  wire        transfer_ack_n,
    // request
    output reg  [31:0] addr,
    output reg  [1:0]  transfer_type,
    output reg  [2:0]  transfer_mode_bits,
    output reg  [1:0]  transfer_size,
    output reg         read_write,
    output reg         transfer_start_n,
    output reg         cache_inhibit_n
);
    // idle bus until the first transfer
    initial
    begin
        {addr, transfer_type, transfer_mode_bits, transfer_size} = 39'h0;
        {read_write, transfer_start_n, cache_inhibit_n} = 3'h7;
    end

    // strobe for one cycle, lines held until the expected acks or 30 cycles, so refusals end too
    task xfer(input logic [31:0] a, input logic rw, input logic [1:0] sz, input logic ci,
              input logic [2:0] tm, input logic [1:0] tt, input int nexp,
              output int acks, output int lat);
        int n;
        begin
            acks = 0;
            lat = -1;
            @(negedge ref_clk);
            addr <= a;
            {read_write, transfer_size, cache_inhibit_n} <= {rw, sz, ci};
            {transfer_mode_bits, transfer_type} <= {tm, tt};
            transfer_start_n <= 1'b0;
            for (n = 0; n < 30 && acks < nexp; n++)
            begin
                @(negedge ref_clk);
                transfer_start_n <= 1'b1;
                if (transfer_ack_n === 1'b0)
                begin
                    acks++;
                    if (lat < 0)
                        lat = n;
                end
            end
            addr <= ~a; // released address lines do not keep the old value
            // bus idle while the controller precharges
            repeat (3) @(negedge ref_clk);
        end
    endtask
endmodule // bus_master

// *** tb/test_cached_dram_controller.sv ***
// self-checking bench for cached_dram_controller
// bus_master plays the processor; the monitor is bound in
`timescale 1ns/1ns
`include "dram_ctrl_regs.vh"
module test_cached_dram_controller;
    reg         ref_clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         processor_reset_in_n = 1'b0;
    wire [31:0] addr;
    wire [1:0]  transfer_type, transfer_size, write_mode, refresh_mode_n;
    wire [1:0]  output_enable_n, write_enable_n;
    wire [2:0]  transfer_mode_bits;
    wire        read_write, transfer_start_n, cache_inhibit_n, transfer_ack_n;
    wire [9:0]  mux_addr_low_banks, mux_addr_high_banks;
    wire        bank0_addr_bit10, bank1_addr_bit10, bank2_addr_bit10, bank3_addr_bit10;
    wire [3:0]  row_enable_n, col_latch_n, chip_select_n;
    int         failures = 0, compares = 0, cyc = 0, rf_cnt = 0, rf_cyc = 0;
    int         acks, lat, lm, i, k;
    logic       rf_prev = 1'b1, re_seen;
    logic [3:0] cal_or;
    logic [9:0] q[$];

    cached_dram_controller i_cached_dram_controller (.*);
    bus_master i_bus_master (.*);

    always #5 ref_clk = ~ref_clk;

    // pin watcher on the settled falling edge
    always @(negedge ref_clk)
    begin
        cyc++;
        if (refresh_mode_n != 2'h3 && rf_prev)
        begin
            rf_cnt++;
            rf_cyc = cyc;
        end
        rf_prev = (refresh_mode_n == 2'h3);
        if (row_enable_n != 4'hF)
            re_seen = 1'b1;
        cal_or = cal_or | ~col_latch_n;
        if (transfer_ack_n === 1'b0)
            q.push_back(mux_addr_low_banks);
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // clear on the rising edge, away from the watcher
    task clr;
        @(posedge ref_clk);
        re_seen = 1'b0;
        cal_or = 4'h0;
        q.delete();
    endtask

    task rd(input logic [31:0] a, input logic [2:0] tm, input logic [1:0] tt);
        clr();
        i_bus_master.xfer(a, 1'b1, `SIZE_LONG, 1'b1, tm, tt, 1, acks, lat);
    endtask

    task wait_rf;
        int n0;
        n0 = rf_cnt;
        // polled off the watcher's edge to avoid a race on rf_cnt
        for (k = 0; k < 7000 && rf_cnt == n0; k++)
            @(posedge ref_clk);
        if (rf_cnt == n0)
        begin
            failures++;
            stop_test();
        end
    endtask

    task t_init;
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (80) @(negedge ref_clk);
        chk(rf_cnt >= 8, 1);
        processor_reset_in_n = 1'b1;
        // the init refresh burst restarts while reset is held and is still running at release; settle in idle before the first start
        repeat (50) @(negedge ref_clk);
        // two misses to every bank as user data
        for (i = 0; i < 8; i++)
        begin
            rd({8'h00, i[2:1], 8'h00, i[0], 13'h0000}, 3'h1, 2'h0);
            chk(acks, 1);
        end
    endtask

    task t_miss_hit;
        rd(32'h0000_6010, 3'h1, 2'h0);
        lm = lat;
        chk(re_seen, 1);
        chk(q[0], 10'h004);
        rd(32'h0000_6020, 3'h1, 2'h0);
        chk(re_seen, 0);
        chk(lat < lm, 1);
        chk(q[0], 10'h008);
    endtask

    task t_decode;
        for (i = 0; i < 8; i++)
        begin
            rd(32'h0000_6020, i[2:0], 2'h0);
            chk(acks, i[1:0] == 2'h1 || i[1:0] == 2'h2);
        end
        rd(32'h0100_6020, 3'h1, 2'h0);
        chk(acks, 0);
        rd(32'h0000_6020, 3'h1, 2'h1);
        chk(acks, 0);
    endtask

    // offset, size and lane count for each write
    task t_write;
        logic [5:0] tbl[4];
        tbl = '{6'h15, 6'h35, 6'h2A, 6'h00};
        for (i = 0; i < 4; i++)
        begin
            clr();
            i_bus_master.xfer({28'h0000_600, 2'h0, tbl[i][5:4]}, 1'b0, tbl[i][3:2], 1'b1,
                              3'h5, 2'h0, 1, acks, lat);
            chk(acks, 1);
            repeat (4) @(negedge ref_clk); // I1, then idle in I2
            chk($countones(cal_or), tbl[i][1:0] == 2'h0 ? 4 : tbl[i][1:0]);
        end
    endtask

    task t_burst;
        for (i = 1; i >= 0; i--)
        begin
            clr();
            i_bus_master.xfer(32'h0000_A008, i[0], `SIZE_LINE, 1'b1, 3'h2, 2'h0, 4, acks, lat);
            chk(acks, 4);
            // a write acks in W1 with the row address still out
            chk(q[0][1:0], i ? 2 : 1);
            for (k = 1; k < 4; k++)
                chk(q[k][1:0], (k + 2) % 4);
        end
        clr();
        i_bus_master.xfer(32'h0000_A008, 1'b1, `SIZE_LINE, 1'b0, 3'h2, 2'h0, 4, acks, lat);
        chk(acks, 1);
    endtask

    task t_refresh;
        wait_rf();
        lm = rf_cyc;
        wait_rf();
        chk(rf_cyc - lm, `REFRESH_CYCLES);
        rd(32'h0000_6020, 3'h1, 2'h0);
        chk(acks, 1);
        chk(q[0], 10'h008);
    endtask

    initial
    begin
        t_init();
        t_miss_hit();
        t_decode();
        t_write();
        t_burst();
        t_refresh();
        stop_test();
    end
endmodule // test_cached_dram_controller
